// [logic/occ_defines.svh]
// occ_defines.svh - offsets, field positions, reset values and codes of the oscillator config decode
`ifndef OCC_DEFINES_SVH
`define OCC_DEFINES_SVH

// register byte offsets on the wishbone slave
`define OCC_ADR_CFG_WORD      8'h00
`define OCC_ADR_CLK_CTRL      8'h04
`define OCC_ADR_CLK_STAT      8'h08
`define OCC_ADR_NVM_PROG      8'h0c
`define OCC_ADR_NVM_ERASE     8'h10

// configuration word layout
`define OCC_CFG_W             14
`define OCC_BIT_FAIL_MON      13
`define OCC_BIT_SWITCH_EN     11
`define OCC_BIT_CLKOUT_N      8
`define OCC_POS_RST_OSC       4
`define OCC_POS_EXT_MODE      0
`define OCC_CFG_UNIMPL_MASK   14'h1688
`define OCC_CFG_BLANK         14'h3fff

// reset oscillator codes
`define OCC_ROSC_EXT          3'h7
`define OCC_ROSC_HF_010       3'h6
`define OCC_ROSC_LF           3'h5
`define OCC_ROSC_SEC          3'h4
`define OCC_ROSC_RSV          3'h3
`define OCC_ROSC_EXT_PLL4     3'h2
`define OCC_ROSC_EXT_PLL2     3'h1
`define OCC_ROSC_HF_110       3'h0

// external oscillator mode codes
`define OCC_EXT_EC_HIGH       3'h7
`define OCC_EXT_EC_MID        3'h6
`define OCC_EXT_EC_LOW        3'h5
`define OCC_EXT_OFF           3'h4
`define OCC_EXT_RSV           3'h3
`define OCC_EXT_HS            3'h2
`define OCC_EXT_XT            3'h1
`define OCC_EXT_LP            3'h0

// hf frequency selects and dividers applied by reset codes
`define OCC_INTERNAL_HF_FREQUENCY_SELECT_CODE_110    3'h2
`define OCC_INTERNAL_HF_FREQUENCY_SELECT_CODE_000    3'h6
`define OCC_CURRENT_CLOCK_DIVIDER_1_1          4'h0

// reset values of the clock control state
`define OCC_RST_CURRENT_OSCILLATOR_SELECT          3'h7
`define OCC_RST_CURRENT_CLOCK_DIVIDER          4'h0
`define OCC_RST_INTERNAL_HF_FREQUENCY_SELECT         3'h2

// status register field positions
`define OCC_ST_POS_CURRENT_OSCILLATOR_SELECT       0
`define OCC_ST_POS_CURRENT_CLOCK_DIVIDER       4
`define OCC_ST_POS_INTERNAL_HF_FREQUENCY_SELECT      8
`define OCC_ST_POS_PFM        12
`define OCC_ST_BIT_FAIL_MON   14
`define OCC_ST_BIT_CLKOUT     15
`define OCC_ST_BIT_EXT_EN     16
`define OCC_ST_BIT_RSV        17
`define OCC_ST_BIT_SWITCH_EN  18
`define OCC_ST_POS_PLL        20

// control register field positions
`define OCC_CT_POS_NEW_OSCILLATOR_SELECT       0
`define OCC_CT_POS_NEW_CLOCK_DIVIDER       4

`endif

// [logic/occ_pkg.sv]
// occ_pkg.sv - types of the oscillator config decode
package occ_pkg;

    typedef enum logic [1:0] {
        OCC_PH_LOAD = 2'b00,
        OCC_PH_RUN  = 2'b01
    } occ_phase_t;

    typedef enum logic [1:0] {
        OCC_PFM_LOW  = 2'b00,
        OCC_PFM_MID  = 2'b01,
        OCC_PFM_HIGH = 2'b10
    } occ_pfm_t;

    typedef enum logic [1:0] {
        OCC_PLL_NONE = 2'b00,
        OCC_PLL_X2   = 2'b01,
        OCC_PLL_X4   = 2'b10
    } occ_pll_t;

    // decoded reset oscillator selection
    typedef struct packed {
        logic [2:0] current_oscillator_select;
        logic [3:0] current_clock_divider;
        logic [2:0] internal_hf_frequency_select;
        occ_pll_t   pll;
        logic       rsv;
    } occ_osc_sel_t;

    // decoded external oscillator mode
    typedef struct packed {
        logic     ext_en;
        logic     ec_or_off;
        occ_pfm_t program_flash_memory;
        logic     rsv;
    } occ_ext_sel_t;

    // wishbone request carried as one bundle
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } occ_wb_req_t;

endpackage : occ_pkg

// [logic/occ_nvm_word.sv]
// occ_nvm_word.sv - nonvolatile configuration word cell with program and bulk erase
`timescale 1ns/1ps
`default_nettype none
`include "occ_defines.svh"

module occ_nvm_word
    import occ_pkg::*;
#(
    parameter int W = `OCC_CFG_W
) (
    input  wire logic         clk_i,
    input  wire logic         por_i,
    input  wire logic         prog_i,
    input  wire logic         erase_i,
    input  wire logic [W-1:0] wdata_i,
    output logic      [W-1:0] rdata_o
);

    typedef struct packed {
        logic [W-1:0] word;
    } occ_nvm_state_t;

    occ_nvm_state_t state_r;
    occ_nvm_state_t state_nxt;

    // programming only clears bits; erase and power-on reset are the only ways back to ones
    always_comb begin
        state_nxt = state_r;
        if (erase_i) begin
            state_nxt.word = W'(`OCC_CFG_BLANK);
        end else if (prog_i) begin
            state_nxt.word = state_r.word & wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (por_i) begin
            state_r <= '{word: W'(`OCC_CFG_BLANK)};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign rdata_o = state_r.word;

endmodule : occ_nvm_word

`default_nettype wire

// [logic/occ_decode.sv]
// occ_decode.sv - oscillator configuration word decode with wishbone register access
`timescale 1ns/1ps
`default_nettype none
`include "occ_defines.svh"

module occ_decode
    import occ_pkg::*;
#(
    parameter int         CFG_W     = `OCC_CFG_W,
    parameter logic [3:0] HF_CURRENT_CLOCK_DIVIDER   = `OCC_CURRENT_CLOCK_DIVIDER_1_1,
    parameter logic [2:0] HF_DFLT_F = `OCC_RST_INTERNAL_HF_FREQUENCY_SELECT
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        por_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic      [2:0]  current_oscillator_select_o,
    output logic      [3:0]  current_clock_divider_o,
    output logic      [2:0]  internal_hf_frequency_select_o,
    output logic      [1:0]  pll_mult_o,
    output logic      [1:0]  pfm_power_o,
    output logic             fail_safe_monitor_en_o,
    output logic             external_oscillator_en_o,
    output logic             cfg_reserved_o,
    output logic             second_oscillator_pin_o,
    output logic             second_oscillator_pin_oe_o
);

    typedef struct packed {
        occ_phase_t   phase;
        logic [13:0]  cfg;
        logic [2:0]   current_oscillator_select;
        logic [3:0]   current_clock_divider;
        logic [2:0]   new_oscillator_select;
        logic [3:0]   new_clock_divider;
        logic [2:0]   internal_hf_frequency_select;
        occ_pfm_t     program_flash_memory;
        occ_pll_t     pll;
        logic         fail_mon;
        logic         switch_en;
        logic         ext_en;
        logic         clkout_act;
        logic         rsv;
        logic [1:0]   div4;
        logic         second_oscillator_pin;
        logic         ack;
        logic [31:0]  dat;
    } occ_state_t;

    localparam occ_state_t RST_STATE = '{
        phase:      OCC_PH_LOAD,
        cfg:        14'(`OCC_CFG_BLANK),
        current_oscillator_select:       `OCC_RST_CURRENT_OSCILLATOR_SELECT,
        current_clock_divider:       `OCC_RST_CURRENT_CLOCK_DIVIDER,
        new_oscillator_select:       `OCC_RST_CURRENT_OSCILLATOR_SELECT,
        new_clock_divider:       `OCC_RST_CURRENT_CLOCK_DIVIDER,
        internal_hf_frequency_select:      `OCC_RST_INTERNAL_HF_FREQUENCY_SELECT,
        program_flash_memory:        OCC_PFM_HIGH,
        pll:        OCC_PLL_NONE,
        fail_mon:   1'b0,
        switch_en:  1'b0,
        ext_en:     1'b0,
        clkout_act: 1'b0,
        rsv:        1'b0,
        div4:       2'h0,
        second_oscillator_pin:       1'b0,
        ack:        1'b0,
        dat:        32'h0
    };

    occ_state_t  state_r;
    occ_state_t  state_nxt;
    occ_wb_req_t req;
    logic [13:0] nvm_word;
    logic        nvm_prog;
    logic        nvm_erase;
    logic [13:0] nvm_wdata;

    // reset oscillator code to current selection
    function automatic occ_osc_sel_t decode_rst_osc(input logic [2:0] code,
                                                    input logic [2:0] hf_dflt);
        occ_osc_sel_t s;
        s.current_oscillator_select  = code;
        s.current_clock_divider  = HF_CURRENT_CLOCK_DIVIDER;
        s.internal_hf_frequency_select = hf_dflt;
        s.pll   = OCC_PLL_NONE;
        s.rsv   = 1'b0;
        unique case (code)
            `OCC_ROSC_EXT:      s.pll = OCC_PLL_NONE;
            `OCC_ROSC_EXT_PLL4: s.pll = OCC_PLL_X4;
            `OCC_ROSC_EXT_PLL2: s.pll = OCC_PLL_X2;
            `OCC_ROSC_HF_010:   s.internal_hf_frequency_select = `OCC_INTERNAL_HF_FREQUENCY_SELECT_CODE_110;
            `OCC_ROSC_HF_110: begin
                s.current_clock_divider  = `OCC_CURRENT_CLOCK_DIVIDER_1_1;
                s.internal_hf_frequency_select = `OCC_INTERNAL_HF_FREQUENCY_SELECT_CODE_000;
            end
            `OCC_ROSC_LF:       s.pll = OCC_PLL_NONE;
            `OCC_ROSC_SEC:      s.pll = OCC_PLL_NONE;
            `OCC_ROSC_RSV:      s.rsv = 1'b1;
        endcase
        return s;
    endfunction : decode_rst_osc

    // external oscillator mode to enable and flash power
    function automatic occ_ext_sel_t decode_ext_mode(input logic [2:0] code);
        occ_ext_sel_t e;
        e.ext_en    = 1'b1;
        e.ec_or_off = 1'b0;
        e.program_flash_memory       = OCC_PFM_LOW;
        e.rsv       = 1'b0;
        unique case (code)
            `OCC_EXT_EC_HIGH: begin
                e.ec_or_off = 1'b1;
                e.program_flash_memory       = OCC_PFM_HIGH;
            end
            `OCC_EXT_EC_MID: begin
                e.ec_or_off = 1'b1;
                e.program_flash_memory       = OCC_PFM_MID;
            end
            `OCC_EXT_EC_LOW:  e.ec_or_off = 1'b1;
            `OCC_EXT_OFF: begin
                e.ext_en    = 1'b0;
                e.ec_or_off = 1'b1;
            end
            `OCC_EXT_RSV: begin
                e.ext_en = 1'b0;
                e.rsv    = 1'b1;
            end
            `OCC_EXT_HS:      e.program_flash_memory = OCC_PFM_HIGH;
            `OCC_EXT_XT:      e.program_flash_memory = OCC_PFM_MID;
            `OCC_EXT_LP:      e.program_flash_memory = OCC_PFM_LOW;
        endcase
        return e;
    endfunction : decode_ext_mode

    // readback view: unimplemented positions forced high
    function automatic logic [13:0] cfg_view(input logic [13:0] w);
        return w | 14'(`OCC_CFG_UNIMPL_MASK);
    endfunction : cfg_view

    assign req = '{
        cyc: wb_cyc_i,
        stb: wb_stb_i,
        we:  wb_we_i,
        adr: wb_adr_i,
        sel: wb_sel_i,
        dat: wb_dat_i
    };

    occ_nvm_word #(
        .W       (CFG_W)
    ) u_nvm (
        .clk_i   (clk_i),
        .por_i   (por_i),
        .prog_i  (nvm_prog),
        .erase_i (nvm_erase),
        .wdata_i (nvm_wdata),
        .rdata_o (nvm_word)
    );

    always_comb begin
        occ_osc_sel_t osel;
        occ_ext_sel_t esel;
        logic         wr_commit;
        logic         rd_take;
        logic [31:0]  rdat;
        osel      = decode_rst_osc(nvm_word[`OCC_POS_RST_OSC +: 3], HF_DFLT_F);
        esel      = decode_ext_mode(state_r.cfg[`OCC_POS_EXT_MODE +: 3]);
        wr_commit = req.cyc && req.stb && req.we && state_r.ack;
        rd_take   = req.cyc && req.stb && !state_r.ack;
        rdat      = 32'h0;
        nvm_prog  = 1'b0;
        nvm_erase = 1'b0;
        // unselected byte lanes leave their bits blank so they stay unprogrammed
        nvm_wdata = {(req.sel[1] ? req.dat[13:8] : 6'h3f),
                     (req.sel[0] ? req.dat[7:0] : 8'hff)};
        state_nxt = state_r;

        unique case (state_r.phase)
            OCC_PH_LOAD: begin
                // one sample per reset, then frozen until the next one
                state_nxt.cfg   = nvm_word;
                state_nxt.current_oscillator_select  = osel.current_oscillator_select;
                state_nxt.new_oscillator_select  = osel.current_oscillator_select;
                state_nxt.current_clock_divider  = osel.current_clock_divider;
                state_nxt.new_clock_divider  = osel.current_clock_divider;
                state_nxt.internal_hf_frequency_select = osel.internal_hf_frequency_select;
                state_nxt.pll   = osel.pll;
                state_nxt.rsv   = osel.rsv;
                state_nxt.phase = OCC_PH_RUN;
            end
            OCC_PH_RUN: begin
                state_nxt.fail_mon  = state_r.cfg[`OCC_BIT_FAIL_MON];
                state_nxt.switch_en = state_r.cfg[`OCC_BIT_SWITCH_EN];
                state_nxt.ext_en    = esel.ext_en;
                state_nxt.program_flash_memory       = esel.program_flash_memory;
                state_nxt.rsv       = state_r.rsv | esel.rsv;
                // bit 8 only matters when the osc pins are not a crystal pair
                state_nxt.clkout_act = esel.ec_or_off &&
                                       !state_r.cfg[`OCC_BIT_CLKOUT_N];
                // software switch: current follows new fields one cycle later
                state_nxt.current_oscillator_select = state_r.new_oscillator_select;
                state_nxt.current_clock_divider = state_r.new_clock_divider;
                if (state_r.new_oscillator_select == `OCC_ROSC_EXT_PLL4) begin
                    state_nxt.pll = OCC_PLL_X4;
                end else if (state_r.new_oscillator_select == `OCC_ROSC_EXT_PLL2) begin
                    state_nxt.pll = OCC_PLL_X2;
                end else begin
                    state_nxt.pll = OCC_PLL_NONE;
                end
            end
            default: state_nxt.phase = OCC_PH_LOAD;
        endcase

        // fosc over four: toggle the pin every second clock
        state_nxt.div4 = state_r.div4 + 2'h1;
        if (state_r.clkout_act) begin
            if (state_r.div4[0]) begin
                state_nxt.second_oscillator_pin = !state_r.second_oscillator_pin;
            end
        end else begin
            state_nxt.second_oscillator_pin = 1'b0;
        end

        // write effects happen on the edge where the master sees ack
        if (wr_commit) begin
            unique case (req.adr)
                `OCC_ADR_CLK_CTRL: begin
                    // locked fields silently keep their value
                    if (state_r.cfg[`OCC_BIT_SWITCH_EN] && req.sel[0]) begin
                        state_nxt.new_oscillator_select = req.dat[`OCC_CT_POS_NEW_OSCILLATOR_SELECT +: 3];
                        state_nxt.new_clock_divider = req.dat[`OCC_CT_POS_NEW_CLOCK_DIVIDER +: 4];
                    end
                end
                `OCC_ADR_NVM_PROG: nvm_prog = 1'b1;
                `OCC_ADR_NVM_ERASE: begin
                    nvm_erase = req.sel[0] && req.dat[0];
                end
                default: nvm_prog = 1'b0;
            endcase
        end

        unique case (req.adr)
            `OCC_ADR_CFG_WORD: rdat = {18'h0, cfg_view(nvm_word)};
            `OCC_ADR_CLK_CTRL: begin
                rdat[`OCC_CT_POS_NEW_OSCILLATOR_SELECT +: 3] = state_r.new_oscillator_select;
                rdat[`OCC_CT_POS_NEW_CLOCK_DIVIDER +: 4] = state_r.new_clock_divider;
            end
            `OCC_ADR_CLK_STAT: begin
                rdat[`OCC_ST_POS_CURRENT_OSCILLATOR_SELECT +: 3]     = state_r.current_oscillator_select;
                rdat[`OCC_ST_POS_CURRENT_CLOCK_DIVIDER +: 4]     = state_r.current_clock_divider;
                rdat[`OCC_ST_POS_INTERNAL_HF_FREQUENCY_SELECT +: 3]    = state_r.internal_hf_frequency_select;
                rdat[`OCC_ST_POS_PFM +: 2]      = state_r.program_flash_memory;
                rdat[`OCC_ST_BIT_FAIL_MON]      = state_r.fail_mon;
                rdat[`OCC_ST_BIT_CLKOUT]        = state_r.clkout_act;
                rdat[`OCC_ST_BIT_EXT_EN]        = state_r.ext_en;
                rdat[`OCC_ST_BIT_RSV]           = state_r.rsv;
                rdat[`OCC_ST_BIT_SWITCH_EN]     = state_r.switch_en;
                rdat[`OCC_ST_POS_PLL +: 2]      = state_r.pll;
            end
            default: rdat = 32'h0;
        endcase

        // one wait state, then ack for one cycle; unmapped reads give zero
        state_nxt.ack = rd_take;
        if (rd_take) begin
            state_nxt.dat = rdat;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= RST_STATE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign wb_dat_o                       = state_r.dat;
    assign wb_ack_o                       = state_r.ack;
    assign current_oscillator_select_o    = state_r.current_oscillator_select;
    assign current_clock_divider_o        = state_r.current_clock_divider;
    assign internal_hf_frequency_select_o = state_r.internal_hf_frequency_select;
    assign pll_mult_o                     = state_r.pll;
    assign pfm_power_o                    = state_r.program_flash_memory;
    assign fail_safe_monitor_en_o         = state_r.fail_mon;
    assign external_oscillator_en_o       = state_r.ext_en;
    assign cfg_reserved_o                 = state_r.rsv;
    assign second_oscillator_pin_o        = state_r.second_oscillator_pin;
    assign second_oscillator_pin_oe_o     = state_r.clkout_act;

endmodule : occ_decode

`default_nettype wire

// [test/occ_decode_props.sv]
// occ_decode_props.sv - concurrent checks on the oscillator config decode ports
`timescale 1ns/1ps
`default_nettype none
`include "occ_defines.svh"
module occ_decode_props
    import occ_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    input  wire logic [2:0]  current_oscillator_select_o,
    input  wire logic [1:0]  pfm_power_o,
    input  wire logic        fail_safe_monitor_en_o,
    input  wire logic        cfg_reserved_o,
    input  wire logic        second_oscillator_pin_o,
    input  wire logic        second_oscillator_pin_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [2:0] rst_win_r;
    logic [2:0] sw_win_r;
    logic       req;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // decode may move only just after a reset or an accepted switch write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_win_r <= 3'h4;
            sw_win_r  <= 3'h0;
        end else begin
            rst_win_r <= (rst_win_r != 3'h0) ? rst_win_r - 3'h1 : 3'h0;
            if (wb_ack_o && wb_we_i && wb_adr_i == `OCC_ADR_CLK_CTRL)
                sw_win_r <= 3'h5;
            else
                sw_win_r <= (sw_win_r != 3'h0) ? sw_win_r - 3'h1 : 3'h0;
        end
    end
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_follows_req: assert property (req |=> wb_ack_o)
        else $error("request not answered in one cycle");
    a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    a_reset_values: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !fail_safe_monitor_en_o
        && current_oscillator_select_o == 3'h7 && pfm_power_o == 2'h2 && !second_oscillator_pin_oe_o)
        else $error("outputs not at reset values");
    a_clkout_quiet: assert property (!second_oscillator_pin_oe_o |-> !second_oscillator_pin_o)
        else $error("clock out pin moves while not driven");
    a_clkout_period: assert property ((second_oscillator_pin_oe_o && $rose(second_oscillator_pin_o)) |=>
        (!second_oscillator_pin_oe_o || second_oscillator_pin_o) ##1
        (!second_oscillator_pin_oe_o || !second_oscillator_pin_o))
        else $error("clock out not a four cycle square wave");
    a_osc_held: assert property ($changed(current_oscillator_select_o) |->
        (rst_win_r != 3'h0 || sw_win_r != 3'h0))
        else $error("current oscillator moved without cause");
    a_monitor_held: assert property ($changed(fail_safe_monitor_en_o) |-> rst_win_r != 3'h0)
        else $error("monitor enable moved outside reset");
    a_unmapped_zero: assert property ((req && !wb_we_i && wb_adr_i == 8'h14) |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_unimpl_ones: assert property ((req && !wb_we_i && wb_adr_i == `OCC_ADR_CFG_WORD) |=>
        (wb_dat_o[13:0] & `OCC_CFG_UNIMPL_MASK) == `OCC_CFG_UNIMPL_MASK)
        else $error("unimplemented word bits not one");
    c_clkout_on: cover property ($rose(second_oscillator_pin_oe_o));
    c_reserved_seen: cover property (cfg_reserved_o);
    c_switch_write: cover property (sw_win_r == 3'h5);
endmodule : occ_decode_props
bind occ_decode occ_decode_props u_props (
    .clk_i                       (clk_i),
    .rst_i                       (rst_i),
    .wb_cyc_i                    (wb_cyc_i),
    .wb_stb_i                    (wb_stb_i),
    .wb_we_i                     (wb_we_i),
    .wb_adr_i                    (wb_adr_i),
    .wb_dat_o                    (wb_dat_o),
    .wb_ack_o                    (wb_ack_o),
    .current_oscillator_select_o (current_oscillator_select_o),
    .pfm_power_o                 (pfm_power_o),
    .fail_safe_monitor_en_o      (fail_safe_monitor_en_o),
    .cfg_reserved_o              (cfg_reserved_o),
    .second_oscillator_pin_o     (second_oscillator_pin_o),
    .second_oscillator_pin_oe_o  (second_oscillator_pin_oe_o)
);
`default_nettype wire

// [test/occ_decode_test.sv]
// occ_decode_test.sv - self-checking bench of the oscillator config decode
`timescale 1ns/1ps
`default_nettype none
`include "occ_defines.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("FAIL t=%0t got %0h exp %0h line %0d", $time, g, e, `__LINE__); end end
module occ_decode_test
    import occ_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, por = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h0;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0, rdat, rd;
    logic [2:0]  current_oscillator_select, internal_hf_frequency_select;
    logic [3:0]  current_clock_divider;
    logic [1:0]  pll, program_flash_memory;
    logic        ack, fmon, exten, rsv, pin, oe;
    int          bad_count = 0, checks = 0;
    always #12.5 clk = ~clk;
    occ_decode dut (.clk_i(clk), .rst_i(rst), .por_i(por), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .current_oscillator_select_o(current_oscillator_select), .current_clock_divider_o(current_clock_divider),
        .internal_hf_frequency_select_o(internal_hf_frequency_select), .pll_mult_o(pll), .pfm_power_o(program_flash_memory),
        .fail_safe_monitor_en_o(fmon), .external_oscillator_en_o(exten), .cfg_reserved_o(rsv),
        .second_oscillator_pin_o(pin), .second_oscillator_pin_oe_o(oe));
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, sel, dat} <= {1'b1, 1'b1, w, a, 4'hf, d};
        // look at ack mid-cycle where it is settled; release at the edge that sees it
        do begin
            @(negedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = rdat;
        if (n >= 20) bad_count++;
        @(posedge clk);
        {cyc, stb, we} <= 3'b000;
    endtask : wb
    task automatic do_reset(input int n);
        @(posedge clk);
        rst <= 1'b1;
        repeat (n) @(posedge clk);
        {rst, por} <= 2'b00;
        repeat (4) @(posedge clk);
    endtask : do_reset
    // erase first: programming can only clear bits
    task automatic load(input logic [13:0] w);
        wb(1'b1, `OCC_ADR_NVM_ERASE, 32'h1);
        wb(1'b1, `OCC_ADR_NVM_PROG, {18'h0, w});
        wb(1'b0, `OCC_ADR_CFG_WORD, 32'h0);
        `CHK(rd[13:0], w | `OCC_CFG_UNIMPL_MASK)
    endtask : load
    task automatic t_blank();
        wb(1'b0, `OCC_ADR_CFG_WORD, 32'h0);
        `CHK(rd[13:0], 14'h3fff)
        `CHK({current_oscillator_select, pll, program_flash_memory}, {3'h7, 2'h0, 2'h2})
        `CHK({fmon, exten, oe, rsv}, 4'b1100)
        wb(1'b0, 8'h14, 32'h0);
        `CHK(rd, 32'h0)
    endtask : t_blank
    task automatic t_rosc();
        for (int c = 0; c < 8; c++) begin
            load(14'h3f8f & ~`OCC_CFG_UNIMPL_MASK | 14'(c << 4));
            do_reset(2);
            `CHK(current_oscillator_select, 3'(c))
            `CHK(pll, (c == 2) ? 2'h2 : (c == 1) ? 2'h1 : 2'h0)
            `CHK(internal_hf_frequency_select, (c == 0) ? 3'h6 : 3'h2)
            `CHK(current_clock_divider, 4'h0)
            `CHK(rsv, 1'(c == 3))
        end
    endtask : t_rosc
    task automatic t_ext();
        int tg;
        logic pv;
        logic [1:0] pe [8] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
        for (int m = 0; m < 8; m++) begin
            load(14'h1e78 | 14'(m));
            // new word must not act before the next reset
            if (m == 0) `CHK(fmon, 1'b1)
            do_reset(2);
            `CHK(fmon, 1'b0)
            `CHK(oe, 1'(m >= 4))
            `CHK(rsv, 1'(m == 3))
            if (m != 3) `CHK({exten, program_flash_memory}, {1'(m != 4), pe[m]})
            tg = 0;
            pv = pin;
            repeat (8) begin
                @(negedge clk);
                if (pin !== pv) tg++;
                pv = pin;
            end
            `CHK(tg, (m >= 4) ? 4 : 0)
        end
    endtask : t_ext
    task automatic t_switch();
        load(14'h3fff);
        do_reset(2);
        wb(1'b0, `OCC_ADR_CLK_STAT, 32'h0);
        `CHK(rd[18], 1'b1)
        wb(1'b1, `OCC_ADR_CLK_CTRL, 32'h35);
        repeat (4) @(posedge clk);
        `CHK({current_oscillator_select, current_clock_divider}, {3'h5, 4'h3})
        load(14'h37ff);
        do_reset(2);
        wb(1'b1, `OCC_ADR_CLK_CTRL, 32'h35);
        repeat (4) @(posedge clk);
        `CHK({current_oscillator_select, current_clock_divider}, {3'h7, 4'h0})
    endtask : t_switch
    task automatic final_report();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report
    initial begin
        do_reset(12);
        t_blank();
        t_rosc();
        t_ext();
        t_switch();
        final_report();
    end
    initial begin
        #(25 * 20000);
        bad_count++;
        final_report();
    end
endmodule : occ_decode_test
`default_nettype wire
